// ---- rtl/sbcst_regs.vh ----
// sbcst_regs.vh - addresses, field positions and reset values of the
// level, regulator and identification status registers.
// assumes 7-bit register addresses from the serial control front end.
`ifndef SBCST_REGS_VH
`define SBCST_REGS_VH

// ----------------------------------------------------------------
// register addresses (7 bit)
// ----------------------------------------------------------------
`define SBCST_ADDR_LEVEL   7'h48
`define SBCST_ADDR_REGSTAT 7'h4C
`define SBCST_ADDR_IDENT   7'h7E

// ----------------------------------------------------------------
// level register fields
// ----------------------------------------------------------------
`define SBCST_LVL_TEST_BIT  7
`define SBCST_LVL_RSVD1_BIT 6
`define SBCST_LVL_CFG_BIT   5
`define SBCST_LVL_WAKE_BIT  0

// ----------------------------------------------------------------
// regulator status fields
// ----------------------------------------------------------------
`define SBCST_RS_BOOST_ACT  7
`define SBCST_RS_DRAIN_SH   6
`define SBCST_RS_BOOST_OPEN 5
`define SBCST_RS_GATE_SH    4
`define SBCST_RS_BUCK_SH    2
`define SBCST_RS_BUCK_OPEN  1
`define SBCST_RS_OUT_RANGE  0
`define SBCST_RS_VALID_MASK 8'hF7
`define SBCST_RS_RESET      8'h00

// ----------------------------------------------------------------
// watchdog failure counter
// ----------------------------------------------------------------
`define SBCST_WD_CNT_MAX   2'h3
`define SBCST_WD_CNT_RESET 2'h0

// ----------------------------------------------------------------
// identification (arbitrary neutral values)
// ----------------------------------------------------------------
`define SBCST_ID_FAMILY  4'hA
`define SBCST_ID_VARIANT 4'h3

`endif

// ---- rtl/sbcst_status_regs.v ----
// sbcst_status_regs.v - read-only level, regulator fault and ident regs.
// assumes a serial front end presenting a 7-bit address and a one-cycle
// read strobe, and detector pulses synchronous to i_clk_sys.
//
// Overview of operation
// - level bit 7 shows the test pin, high meaning development mode.
// - in development mode a bad watchdog trigger must not cause reset.
// - level bit 6 always reads one.
// - level bit 5 mirrors the fail-output config bit, read-only here.
// - config zero fails outputs on second bad trigger, one on first.
// - level bit 0 at 0x48 shows the high-voltage wake input level.
// - level bits 4:1 and regulator status bit 3 always read zero.
// - regulator bit 7 at 0x4C sets when the boost has been active.
// - regulator bit 6 sets on boost drain or sense-pos short to ground.
// - regulator bit 5 is the OR of diode, resistor and ground losses.
// - regulator bit 4 sets on boost gate short to ground or supply.
// - regulator bit 2 sets on buck switch short to ground or battery.
// - regulator bit 1 sets on buck switch open.
// - ident at 0x7E holds a 4-bit family code in bits 7:4.
`timescale 1ns/1ps
`include "sbcst_regs.vh"
`default_nettype none

module sbcst_status_regs (
    input  wire       i_clk_sys,
    input  wire       i_sys_rst,
    input  wire       i_test_pin_level,
    input  wire       i_fail_out_cfg_bit,
    input  wire       i_hv_wake_input_level,
    input  wire       i_wd_trigger_fail,
    input  wire       i_boost_active,
    input  wire       i_boost_drain_short,
    input  wire       i_sense_pos_short,
    input  wire       i_boost_diode_loss,
    input  wire       i_sense_pos_res_loss,
    input  wire       i_sense_neg_gnd_loss,
    input  wire       i_boost_gate_short,
    input  wire       i_buck_switch_short,
    input  wire       i_buck_switch_open,
    input  wire       i_main_out_range,
    input  wire [6:0] i_rd_addr,
    input  wire       i_rd_strobe,
    output reg  [7:0] o_rd_data,
    output reg        o_fail_outputs,
    output reg        o_wd_reset_req
);

    reg  [7:0] reg_stat_r;
    wire [7:0] reg_stat_nxt;
    reg  [7:0] rd_mux;
    reg  [7:0] rd_data_nxt;
    reg  [1:0] wd_fail_cnt_r;
    reg  [1:0] wd_fail_cnt_nxt;
    reg        fail_outputs_nxt;
    reg        wd_reset_req_nxt;
    wire       wd_fail_seen;
    wire [7:0] level_word;
    wire [7:0] ident_word;
    wire [7:0] reg_stat_word;
    wire [7:0] det_set;
    wire       clr_stat;
    // named fields of the three registers
    wire       test_pin_level;
    wire       fail_out_cfg_mirror;
    wire       boost_active_flag;
    wire       boost_drain_short_flag;
    wire       boost_open_flag;
    wire       boost_gate_short_flag;
    wire       buck_switch_short_flag;
    wire       buck_switch_open_flag;
    wire       main_out_range_flag;
    wire [3:0] family_code;
    wire [3:0] variant_code;
    genvar     gi;

    // flags that exist; the reserved bit stays clear
    localparam [7:0] VALID_MASK = `SBCST_RS_VALID_MASK;

    // ------------------------------------------------------------
    // detector bit mapping
    // ------------------------------------------------------------
    assign det_set[`SBCST_RS_BOOST_ACT]  = i_boost_active;
    assign det_set[`SBCST_RS_DRAIN_SH]   = i_boost_drain_short |
                                           i_sense_pos_short;
    assign det_set[`SBCST_RS_BOOST_OPEN] = i_boost_diode_loss |
                                           i_sense_pos_res_loss |
                                           i_sense_neg_gnd_loss;
    assign det_set[`SBCST_RS_GATE_SH]    = i_boost_gate_short;
    assign det_set[3]                    = 1'b0;
    assign det_set[`SBCST_RS_BUCK_SH]    = i_buck_switch_short;
    assign det_set[`SBCST_RS_BUCK_OPEN]  = i_buck_switch_open;
    assign det_set[`SBCST_RS_OUT_RANGE]  = i_main_out_range;

    // read of the regulator register clears the flags
    assign clr_stat = i_rd_strobe && (i_rd_addr == `SBCST_ADDR_REGSTAT);

    // ------------------------------------------------------------
    // live level word and identification
    // ------------------------------------------------------------
    assign level_word = {i_test_pin_level,
                         1'b1,
                         i_fail_out_cfg_bit,
                         4'h0,
                         i_hv_wake_input_level};
    // identification fields, fixed in silicon
    assign family_code  = `SBCST_ID_FAMILY;
    assign variant_code = `SBCST_ID_VARIANT;
    assign ident_word   = {family_code,
                           variant_code};

    // level fields also read by the watchdog logic
    assign test_pin_level      = i_test_pin_level;
    assign fail_out_cfg_mirror = i_fail_out_cfg_bit;

    // ------------------------------------------------------------
    // sticky regulator flags
    // ------------------------------------------------------------
    // one sticky flag per bit, a new detection wins over the read clear
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_flag
            assign reg_stat_nxt[gi] = VALID_MASK[gi] &
                                      (det_set[gi] |
                                       (reg_stat_r[gi] & ~clr_stat));
        end
    endgenerate

    // named views of the stored flags
    assign boost_active_flag      = reg_stat_r[`SBCST_RS_BOOST_ACT];
    assign boost_drain_short_flag = reg_stat_r[`SBCST_RS_DRAIN_SH];
    assign boost_open_flag        = reg_stat_r[`SBCST_RS_BOOST_OPEN];
    assign boost_gate_short_flag  = reg_stat_r[`SBCST_RS_GATE_SH];
    assign buck_switch_short_flag = reg_stat_r[`SBCST_RS_BUCK_SH];
    assign buck_switch_open_flag  = reg_stat_r[`SBCST_RS_BUCK_OPEN];
    assign main_out_range_flag    = reg_stat_r[`SBCST_RS_OUT_RANGE];

    // regulator word rebuilt from its fields, bit 3 reserved
    assign reg_stat_word = {boost_active_flag,
                            boost_drain_short_flag,
                            boost_open_flag,
                            boost_gate_short_flag,
                            1'b0,
                            buck_switch_short_flag,
                            buck_switch_open_flag,
                            main_out_range_flag};

    // flag register, cleared by reset
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            reg_stat_r <= `SBCST_RS_RESET;
        end else begin
            reg_stat_r <= reg_stat_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data path
    // ------------------------------------------------------------
    // register select by address, unmapped reads zero
    always @* begin
        case (i_rd_addr)
            `SBCST_ADDR_LEVEL:   rd_mux = level_word;
            `SBCST_ADDR_REGSTAT: rd_mux = reg_stat_word;
            `SBCST_ADDR_IDENT:   rd_mux = ident_word;
            default:             rd_mux = 8'h00;
        endcase
    end

    // next read data: a new word on a strobe, otherwise hold
    always @* begin
        if (i_rd_strobe) begin
            rd_data_nxt = rd_mux;
        end else begin
            rd_data_nxt = o_rd_data;
        end
    end

    // data captured on the strobe, held until the next one
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            o_rd_data <= 8'h00;
        end else begin
            o_rd_data <= rd_data_nxt;
        end
    end

    // ------------------------------------------------------------
    // watchdog failure handling
    // ------------------------------------------------------------
    // a failure already counted since reset
    assign wd_fail_seen = (wd_fail_cnt_r != `SBCST_WD_CNT_RESET);

    // next counter and output values from the failure pulse
    always @* begin
        wd_fail_cnt_nxt  = wd_fail_cnt_r;
        fail_outputs_nxt = o_fail_outputs;
        wd_reset_req_nxt = i_wd_trigger_fail && !test_pin_level;
        if (i_wd_trigger_fail) begin
            if (wd_fail_cnt_r != `SBCST_WD_CNT_MAX) begin
                wd_fail_cnt_nxt = wd_fail_cnt_r + 2'h1;
            end
            if (fail_out_cfg_mirror || wd_fail_seen) begin
                fail_outputs_nxt = 1'b1;
            end
        end
    end

    // counter and outputs; fail outputs latch until reset
    always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
            wd_fail_cnt_r  <= `SBCST_WD_CNT_RESET;
            o_fail_outputs <= 1'b0;
            o_wd_reset_req <= 1'b0;
        end else begin
            wd_fail_cnt_r  <= wd_fail_cnt_nxt;
            o_fail_outputs <= fail_outputs_nxt;
            o_wd_reset_req <= wd_reset_req_nxt;
        end
    end

endmodule // sbcst_status_regs

`default_nettype wire

// ---- dv/sbcst_status_regs_asserts.sv ----
// port checks on the status register block
// assumes one clock domain and a synchronous active-high reset
`timescale 1ns/1ps
`include "sbcst_regs.vh"
`default_nettype none
module sbcst_chk (
    input wire logic       i_clk_sys,
    input wire logic       i_sys_rst,
    input wire logic       i_wd_trigger_fail,
    input wire logic       i_test_pin_level,
    input wire logic       i_fail_out_cfg_bit,
    input wire logic       i_hv_wake_input_level,
    input wire logic       i_boost_active,
    input wire logic       i_rd_strobe,
    input wire logic       o_fail_outputs,
    input wire logic       o_wd_reset_req,
    input wire logic [6:0] i_rd_addr,
    input wire logic [7:0] o_rd_data
);
    logic seen_r;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_sys_rst);
    // remembers any failed trigger since reset
    always @(posedge i_clk_sys)
        seen_r <= !i_sys_rst && (seen_r || i_wd_trigger_fail);
    level_map_a:
    assert property (i_rd_strobe && i_rd_addr == 7'h48 |=> o_rd_data ==
        {$past(i_test_pin_level), 1'b1, $past(i_fail_out_cfg_bit), 4'h0,
        $past(i_hv_wake_input_level)}) else $error("bad level read");
    ident_read_a:
    assert property (i_rd_strobe && i_rd_addr == 7'h7E |=> o_rd_data ==
        {`SBCST_ID_FAMILY, `SBCST_ID_VARIANT}) else $error("bad ident");
    boost_set_a:
    assert property (i_boost_active ##1 !i_rd_strobe ##1 i_rd_strobe &&
        i_rd_addr == 7'h4C |=> o_rd_data[7]) else $error("boost lost");
    flag_clear_a:
    assert property ((i_rd_strobe && i_rd_addr == 7'h4C && !i_boost_active)
        [*2] |=> !o_rd_data[7]) else $error("flag not cleared");
    wd_req_a:
    assert property (i_wd_trigger_fail && !i_test_pin_level |=>
        o_wd_reset_req) else $error("no reset request");
    dev_mode_a:
    assert property (!(i_wd_trigger_fail && !i_test_pin_level) |=>
        !o_wd_reset_req) else $error("stray reset request");
    fail_fire_a:
    assert property (i_wd_trigger_fail && (i_fail_out_cfg_bit || seen_r)
        |=> o_fail_outputs) else $error("fail outputs late");
    fail_first_a:
    assert property (i_wd_trigger_fail && !seen_r && !i_fail_out_cfg_bit
        |=> !o_fail_outputs) else $error("fail outputs early");
endmodule // sbcst_chk
bind sbcst_status_regs sbcst_chk chk_u (.i_clk_sys, .i_sys_rst,
    .i_wd_trigger_fail, .i_test_pin_level, .i_fail_out_cfg_bit,
    .i_hv_wake_input_level, .i_boost_active, .i_rd_strobe,
    .o_fail_outputs, .o_wd_reset_req, .i_rd_addr, .o_rd_data);
`default_nettype wire

// ---- dv/sbcst_mcu_model.sv ----
// controller side: issues register reads on the strobe interface
// assumes calls start just after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module sbcst_mcu_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rd_data,
    output var  logic [6:0] o_rd_addr,
    output var  logic       o_rd_strobe
);
    // idle bus at time zero
    initial begin
        o_rd_addr = 7'h00;
        o_rd_strobe = 1'b0;
    end
    // n back-to-back strobes at one address, last byte returned
    task automatic rd(input logic [6:0] a, input int n,
                      output logic [7:0] d);
        @(posedge i_clk_sys) #1;
        o_rd_addr = a;
        o_rd_strobe = 1'b1;
        repeat (n) @(posedge i_clk_sys);
        #1;
        d = i_rd_data;
        o_rd_strobe = 1'b0;
        o_rd_addr = ~a;
    endtask
endmodule // sbcst_mcu_model
`default_nettype wire

// ---- dv/tb_sbcst_status_regs.sv ----
// self-checking bench for the status register block
// assumes the controller model and the bound checker
`timescale 1ns/1ps
`include "sbcst_regs.vh"
`default_nettype none
module tb_sbcst_status_regs;
    logic       clk = 1'b0, rst = 1'b1, tp = 1'b0, cf = 1'b0, wk = 1'b0;
    logic       wd = 1'b0, rs, fo, wr;
    logic [9:0] det = 10'h000;
    logic [6:0] ra;
    logic [7:0] rdat, d;
    int         n_fail = 0, n_tests = 0, cyc = 0;
    int         bm [10] = '{0, 1, 2, 4, 5, 5, 5, 6, 6, 7};
    always #20 clk = ~clk;
    sbcst_status_regs dut_u (.i_clk_sys(clk), .i_sys_rst(rst),
        .i_test_pin_level(tp), .i_fail_out_cfg_bit(cf),
        .i_hv_wake_input_level(wk), .i_wd_trigger_fail(wd),
        .i_boost_active(det[9]), .i_boost_drain_short(det[8]),
        .i_sense_pos_short(det[7]), .i_boost_diode_loss(det[6]),
        .i_sense_pos_res_loss(det[5]), .i_sense_neg_gnd_loss(det[4]),
        .i_boost_gate_short(det[3]), .i_buck_switch_short(det[2]),
        .i_buck_switch_open(det[1]), .i_main_out_range(det[0]),
        .i_rd_addr(ra), .i_rd_strobe(rs), .o_rd_data(rdat),
        .o_fail_outputs(fo), .o_wd_reset_req(wr));
    sbcst_mcu_model mcu_u (.i_clk_sys(clk), .i_rd_data(rdat),
        .o_rd_addr(ra), .o_rd_strobe(rs));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            n_fail = n_fail + 1;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        if (n_fail == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic reset_dut();
        rst = 1'b1;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
    endtask
    // one failed trigger pulse, outputs settled on return
    task automatic wd_fail();
        @(posedge clk) #1 wd = 1'b1;
        @(posedge clk) #1 wd = 1'b0;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 1000) begin
            n_fail = n_fail + 1;
            wrap_up();
        end
    end
    initial begin
        reset_dut();
        for (int i = 0; i < 8; i++) begin
            {tp, cf, wk} = i[2:0];
            mcu_u.rd(7'h48, 1, d);
            chk(d, {tp, 1'b1, cf, 4'h0, wk});
        end
        mcu_u.rd(7'h7E, 1, d);
        chk(d, {`SBCST_ID_FAMILY, `SBCST_ID_VARIANT});
        mcu_u.rd(7'h00, 1, d);
        chk(d, 8'h00);
        // each detector pulse sets one flag, a read clears it
        for (int i = 0; i < 10; i++) begin
            det = 10'h001 << i;
            @(posedge clk) #1 det = 10'h000;
            mcu_u.rd(7'h4C, 1, d);
            chk(d, 8'h01 << bm[i]);
            mcu_u.rd(7'h4C, 2, d);
            chk(d, 8'h00);
        end
        // second failure fires outputs with config low
        tp = 1'b0;
        cf = 1'b0;
        wd_fail();
        chk(wr, 1'b1);
        chk(fo, 1'b0);
        wd_fail();
        chk(fo, 1'b1);
        tp = 1'b1;
        wd_fail();
        chk(wr, 1'b0);
        // first failure suffices with config high
        cf = 1'b1;
        reset_dut();
        wd_fail();
        chk(fo, 1'b1);
        wrap_up();
    end
endmodule // tb_sbcst_status_regs
`default_nettype wire
